// ### pss_imem_model.sv
/*
  Program memory and instruction decoder standing beside the sequencer.
  Assumes the bench loads words into mem after time zero.
*/
`timescale 1ns/100ps
module pss_imem_model (
  input  wire logic [pss_pkg::PC_W-1:0]   imem_addr,
  output logic      [pss_pkg::INSN_W-1:0] imem_data,
  input  wire logic [pss_pkg::INSN_W-1:0] exec_insn,
  output logic                            dec_jump,
  output logic                            dec_call,
  output logic                            dec_ret,
  output logic                            dec_return_from_interrupt_insn,
  output logic                            dec_skip
);
  logic [pss_pkg::INSN_W-1:0] mem [4096];

  // Blank program, every word an ordinary instruction
  initial
  begin
    foreach (mem[i]) mem[i] = 16'h0000;
  end

  // Word at the fetch address, always driven
  assign imem_data = mem[imem_addr];

  // Opcode in the top nibble, branch target in the low twelve bits
  assign dec_jump = exec_insn[15:12] == 4'h1;
  assign dec_call = exec_insn[15:12] == 4'h2;
  assign dec_ret  = exec_insn[15:12] == 4'h3;
  assign dec_return_from_interrupt_insn = exec_insn[15:12] == 4'h4;
  assign dec_skip = exec_insn[15:12] == 4'h5;
endmodule

// ### pss_pkg.sv
/*
  Shared constants for the program sequencer: widths, phase codes,
  register offsets and field positions, reset and interrupt vectors.
  Assumes a 12-bit APB byte address and 32-bit data.
*/
package pss_pkg;

  // Core widths
  localparam int PC_W     = 12;
  localparam int PAGE_W   = 8;
  localparam int INSN_W   = 16;
  localparam int NUM_IRQ  = 6;
  localparam int STK_DEP  = 8;
  localparam int STK_IW   = 3;
  localparam int APB_AW   = 12;
  localparam int APB_DW   = 32;

  // Instruction cycle phases, one instruction cycle is CYCLE_PHASES
  typedef enum logic [1:0] {
    PSS_T1 = 2'b00,
    PSS_T2 = 2'b01,
    PSS_T3 = 2'b10,
    PSS_T4 = 2'b11
  } pss_phase_t;

  // Register byte offsets
  localparam logic [APB_AW-1:0] OFS_PCL    = 12'h000;
  localparam logic [APB_AW-1:0] OFS_STATUS = 12'h004;
  localparam logic [APB_AW-1:0] OFS_IRQ_EN = 12'h008;
  localparam logic [APB_AW-1:0] OFS_CTRL   = 12'h00C;

  // Field positions
  localparam int STATUS_PHASE_LSB = 8;
  localparam int CTRL_GIE_BIT     = 0;

  // Reset values and counter steps
  localparam logic [PC_W-1:0]    PC_RESET   = 12'h000;
  localparam logic [NUM_IRQ-1:0] EN_RESET   = 6'h00;
  localparam logic               GIE_RESET  = 1'b0;
  localparam logic [PC_W-1:0]    PC_STEP    = 12'h001;
  localparam logic [PC_W-1:0]    PC_SKIP    = 12'h002;

  // Vectors, lowest index has highest priority
  localparam logic [PC_W-1:0] VEC_RESET = 12'h000;
  localparam logic [PC_W-1:0] VECTORS [NUM_IRQ] = '{
    12'h004,  // External pin
    12'h008,  // Timer 0 overflow
    12'h00C,  // Timer 1 overflow
    12'h010,  // Tone receiver
    12'h014,  // Real-time clock
    12'h018   // Multi-function
  };

endpackage

// ### pss_return_stack.sv
/*
  Eight-level return stack holding program counter values only.
  Assumes push and pop never arrive together; no software path exists.
*/
`timescale 1ns/100ps
module pss_return_stack #(
  parameter int DEPTH = pss_pkg::STK_DEP,
  parameter int AW    = pss_pkg::PC_W,
  parameter int IW    = pss_pkg::STK_IW
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          ce,
  input  wire logic          push,
  input  wire logic          pop,
  input  wire logic [AW-1:0] push_data,
  output logic      [AW-1:0] top_data,
  output logic               full
);

  logic [AW-1:0] mem [DEPTH];
  logic [IW-1:0] stack_index_reg;
  logic [IW:0]   count_reg;
  logic [IW-1:0] index_up;
  logic [IW-1:0] index_dn;

  // Wrapping index arithmetic
  assign index_up = (stack_index_reg == IW'(DEPTH - 1)) ? '0
                    : stack_index_reg + IW'(1);
  assign index_dn = (stack_index_reg == '0) ? IW'(DEPTH - 1)
                    : stack_index_reg - IW'(1);
  assign top_data = mem[index_dn];
  assign full     = (count_reg == (IW + 1)'(DEPTH));

  // Entry storage
  always_ff @(posedge pclk)
  begin
    if (ce && push)
      mem[stack_index_reg] <= push_data;
  end

  // Index and fill level; reset points at the empty top
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stack_index_reg <= '0;
      count_reg       <= '0;
    end
    else if (ce && push)
    begin
      stack_index_reg <= index_up;
      if (!full)
        count_reg <= count_reg + (IW + 1)'(1);
    end
    else if (ce && pop)
    begin
      stack_index_reg <= index_dn;
      if (count_reg != '0)
        count_reg <= count_reg - (IW + 1)'(1);
    end
  end

endmodule

// ### pss_sequencer.sv
/*
  Program sequencer: four-phase cycle, fetch/execute overlap, program
  counter loads, return stack, interrupt hold-off, APB register slave.
  Assumes an outside decoder drives dec_* from exec_insn, and program
  memory presents the word at imem_addr before the end of T4.
*/
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/100ps
module pss_sequencer #(
  parameter int PC_W    = pss_pkg::PC_W,
  parameter int NUM_IRQ = pss_pkg::NUM_IRQ
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        ce,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [pss_pkg::APB_AW-1:0]  paddr,
  input  wire logic [pss_pkg::APB_DW-1:0]  pwdata,
  output logic      [pss_pkg::APB_DW-1:0]  prdata,
  output logic                             pready,
  output logic                             pslverr,
  output logic      [PC_W-1:0]             imem_addr,
  input  wire logic [pss_pkg::INSN_W-1:0]  imem_data,
  output logic      [pss_pkg::INSN_W-1:0]  exec_insn,
  output logic                             exec_valid,
  output logic      [3:0]                  cycle_phases,
  input  wire logic                        dec_jump,
  input  wire logic                        dec_call,
  input  wire logic                        dec_ret,
  input  wire logic                        dec_return_from_interrupt_insn,
  input  wire logic                        dec_skip,
  input  wire logic [NUM_IRQ-1:0]          irq_req,
  output logic                             int_ack
);

  pss_pkg::pss_phase_t        phase_reg;
  logic [PC_W-1:0]            pc_reg, pc_next, vec_addr, stack_top;
  logic [NUM_IRQ-1:0]         pend_reg, en_reg, ack_vec;
  logic [pss_pkg::PAGE_W-1:0] pcl_data_reg;
  logic [pss_pkg::APB_DW-1:0] rd_mux;
  logic                       first_reg, gie_reg, pcl_pend_reg, rd_ok_reg;
  logic                       hit, apb_wr, bnd, branch, flush, stack_full;
  logic                       do_jump, do_call, do_ret, do_return_from_interrupt_insn, do_skip;
  logic                       take_int, take_pcl;

  // Boundary at the end of T4; executed class, jump first
  assign bnd = ce && (phase_reg == pss_pkg::PSS_T4);
  assign do_jump = exec_valid && dec_jump;
  assign do_call = exec_valid && dec_call && !dec_jump;
  assign do_ret  = exec_valid && dec_ret && !dec_jump && !dec_call;
  assign do_return_from_interrupt_insn = exec_valid && dec_return_from_interrupt_insn && !dec_jump && !dec_call
                   && !dec_ret;
  assign do_skip = exec_valid && dec_skip && !dec_jump && !dec_call
                   && !dec_ret && !dec_return_from_interrupt_insn;
  assign branch  = do_jump || do_call || do_ret || do_return_from_interrupt_insn || do_skip;

  // Low byte write waits for a branch-free boundary; interrupt needs room
  assign take_pcl = pcl_pend_reg && !branch;
  assign take_int = gie_reg && (|pend_reg) && !stack_full
                    && !branch && !pcl_pend_reg;
  assign flush    = branch || take_int || take_pcl || first_reg;

  // Priority pick of the pending source and its vector
  always_comb
  begin
    ack_vec  = '0;
    vec_addr = pss_pkg::VEC_RESET;
    for (int i = NUM_IRQ - 1; i >= 0; i--)
    begin
      if (pend_reg[i])
      begin
        ack_vec  = NUM_IRQ'(1) << i;
        vec_addr = pss_pkg::VECTORS[i];
      end
    end
  end

  // Address of the next fetch
  always_comb
  begin
    pc_next = pc_reg;
    if (do_jump || do_call)
      pc_next = exec_insn[PC_W-1:0];
    else if (do_ret || do_return_from_interrupt_insn)
      pc_next = stack_top;
    else if (do_skip)
      pc_next = pc_reg;
    else if (take_int)
      pc_next = vec_addr;
    else if (take_pcl)
      pc_next = {pc_reg[PC_W-1:pss_pkg::PAGE_W], pcl_data_reg};
  end

  // Phase generator
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      phase_reg <= pss_pkg::PSS_T1;
    else if (ce)
    begin
      unique case (phase_reg)
        pss_pkg::PSS_T1: phase_reg <= pss_pkg::PSS_T2;
        pss_pkg::PSS_T2: phase_reg <= pss_pkg::PSS_T3;
        pss_pkg::PSS_T3: phase_reg <= pss_pkg::PSS_T4;
        pss_pkg::PSS_T4: phase_reg <= pss_pkg::PSS_T1;
      endcase
    end
  end

  // Phase strobes, one-hot CYCLE_PHASES
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cycle_phases <= 4'h1;
    else if (ce)
      cycle_phases <= {cycle_phases[2:0], cycle_phases[3]};
  end

  // Fetch and counter increment at the start of T1
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pc_reg    <= pss_pkg::PC_RESET;
      imem_addr <= pss_pkg::PC_RESET;
      first_reg <= 1'b1;
    end
    else if (bnd)
    begin
      imem_addr <= pc_next;
      pc_reg    <= pc_next + pss_pkg::PC_STEP;
      first_reg <= 1'b0;
    end
  end

  // Prefetched word moves to execute; flushed slots become empty cycles
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      exec_insn  <= '0;
      exec_valid <= 1'b0;
    end
    else if (bnd)
    begin
      exec_insn  <= imem_data;
      exec_valid <= !flush;
    end
  end

  // Return stack, index kept inside and never mapped
  pss_return_stack #(
    .DEPTH (pss_pkg::STK_DEP),
    .AW    (PC_W),
    .IW    (pss_pkg::STK_IW)
  ) u_stack (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .push      (bnd && (do_call || take_int)),
    .pop       (bnd && (do_ret || do_return_from_interrupt_insn)),
    .push_data (imem_addr),
    .top_data  (stack_top),
    .full      (stack_full)
  );

  // Pending flags: enabled requests latch even when the stack is full
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pend_reg <= '0;
    else if (ce)
    begin
      for (int i = 0; i < NUM_IRQ; i++)
      begin
        if (irq_req[i] && en_reg[i])
          pend_reg[i] <= 1'b1;
        else if ((bnd && take_int && ack_vec[i])
                 || (apb_wr && paddr == pss_pkg::OFS_STATUS
                     && pwdata[i]))
          pend_reg[i] <= 1'b0;
      end
    end
  end

  // Acknowledge pulse during the first T1 of the vector jump
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_ack <= 1'b0;
    else if (ce)
      int_ack <= bnd && take_int;
  end

  // Source enables and global enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_reg  <= pss_pkg::EN_RESET;
      gie_reg <= pss_pkg::GIE_RESET;
    end
    else if (ce)
    begin
      if (apb_wr && paddr == pss_pkg::OFS_IRQ_EN)
        en_reg <= pwdata[NUM_IRQ-1:0];
      if (bnd && take_int)
        gie_reg <= 1'b0;
      else if (bnd && do_return_from_interrupt_insn)
        gie_reg <= 1'b1;
      else if (apb_wr && paddr == pss_pkg::OFS_CTRL)
        gie_reg <= pwdata[pss_pkg::CTRL_GIE_BIT];
    end
  end

  // Low byte write held until the next usable boundary
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pcl_pend_reg <= 1'b0;
      pcl_data_reg <= '0;
    end
    else if (ce)
    begin
      if (apb_wr && paddr == pss_pkg::OFS_PCL)
      begin
        pcl_pend_reg <= 1'b1;
        pcl_data_reg <= pwdata[pss_pkg::PAGE_W-1:0];
      end
      else if (bnd && take_pcl)
        pcl_pend_reg <= 1'b0;
    end
  end

  // APB decode and handshake
  assign hit = (paddr == pss_pkg::OFS_PCL) || (paddr == pss_pkg::OFS_STATUS)
               || (paddr == pss_pkg::OFS_IRQ_EN)
               || (paddr == pss_pkg::OFS_CTRL);
  assign pready  = psel && penable && ce && rd_ok_reg;
  assign pslverr = pready && !hit;
  assign apb_wr  = pready && pwrite && hit;

  // Read multiplexer
  always_comb
  begin
    rd_mux = '0;
    unique case (paddr)
      pss_pkg::OFS_PCL:    rd_mux[pss_pkg::PAGE_W-1:0] =
                             pc_reg[pss_pkg::PAGE_W-1:0];
      pss_pkg::OFS_STATUS:
      begin
        rd_mux[NUM_IRQ-1:0] = pend_reg;
        rd_mux[pss_pkg::STATUS_PHASE_LSB +: 2] = phase_reg;
      end
      pss_pkg::OFS_IRQ_EN: rd_mux[NUM_IRQ-1:0] = en_reg;
      pss_pkg::OFS_CTRL:   rd_mux[pss_pkg::CTRL_GIE_BIT] = gie_reg;
      default:             rd_mux = '0;
    endcase
  end

  // Read data captured while selected; one sampled cycle arms pready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata    <= '0;
      rd_ok_reg <= 1'b0;
    end
    else if (ce)
    begin
      rd_ok_reg <= psel && !pready;
      if (psel && !pready)
        prdata <= rd_mux;
    end
  end

  // Checks on sequencing
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_bnd_jump;
    bnd && do_jump;
  endsequence
  sequence s_empty_slot;
    !exec_valid [*3];
  endsequence
  a_phase_rotate: assert property (
    ce && phase_reg == pss_pkg::PSS_T4 |=> phase_reg == pss_pkg::PSS_T1)
    else $error("phase did not return to T1");
  a_fetch_step: assert property (
    bnd && !flush |=> imem_addr == $past(imem_addr) + pss_pkg::PC_STEP)
    else $error("counter did not step by one");
  a_branch_empty: assert property (
    bnd && (do_jump || do_call) |=> s_empty_slot)
    else $error("branch without empty cycle");
  a_jump_target: assert property (
    s_bnd_jump |=> imem_addr == $past(exec_insn[PC_W-1:0]))
    else $error("jump target not loaded");
  a_skip_two: assert property (
    bnd && do_skip |=> imem_addr + pss_pkg::PC_STEP
      == $past(imem_addr) + pss_pkg::PC_SKIP && !exec_valid)
    else $error("skip did not advance by two");
  a_call_push: assert property (
    bnd && do_call |=> stack_top == $past(imem_addr))
    else $error("call did not push return address");
  a_ret_pop: assert property (
    bnd && (do_ret || do_return_from_interrupt_insn) |=> imem_addr == $past(stack_top))
    else $error("return did not reload counter");
  a_full_hold: assert property (
    int_ack |-> $past(!stack_full))
    else $error("acknowledge with full stack");
  a_pcl_page: assert property (
    bnd && take_pcl |=> imem_addr[PC_W-1:pss_pkg::PAGE_W]
      == $past(pc_reg[PC_W-1:pss_pkg::PAGE_W]) && !exec_valid)
    else $error("low byte write left page");
endmodule

// ### tb_top.sv
/*
  Self-checking bench for the program sequencer.
  Assumes the decoder encoding of pss_imem_model and the APB map.
*/
`timescale 1ns/100ps
module tb_top;
  logic        pclk, presetn, ce, psel, penable, pwrite;
  logic [11:0] paddr, imem_addr, a;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, er, exec_valid, int_ack;
  logic [15:0] imem_data, exec_insn;
  logic [3:0]  cycle_phases;
  logic        dec_jump, dec_call, dec_ret, dec_return_from_interrupt_insn, dec_skip;
  logic [5:0]  irq_req;
  int          miscompares, n_checks, acks;

  pss_sequencer pss_sequencer_inst (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .imem_addr(imem_addr), .imem_data(imem_data),
    .exec_insn(exec_insn), .exec_valid(exec_valid),
    .cycle_phases(cycle_phases), .dec_jump(dec_jump),
    .dec_call(dec_call), .dec_ret(dec_ret), .dec_return_from_interrupt_insn(dec_return_from_interrupt_insn),
    .dec_skip(dec_skip), .irq_req(irq_req), .int_ack(int_ack));

  pss_imem_model pss_imem_model_inst (.imem_addr(imem_addr),
    .imem_data(imem_data), .exec_insn(exec_insn), .dec_jump(dec_jump),
    .dec_call(dec_call), .dec_ret(dec_ret), .dec_return_from_interrupt_insn(dec_return_from_interrupt_insn),
    .dec_skip(dec_skip));

  // Clock, 5 ns period
  always #2.5 pclk = ~pclk;

  // Acknowledge pulse counter
  always @(posedge pclk)
    if (int_ack === 1'b1)
      acks <= acks + 1;

  task automatic end_sim;
    if (miscompares == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
    n_checks++;
    if (got !== ex)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // Wait for the next boundary edge and judge fetch address and slot
  task automatic step(logic [11:0] ea, logic ev);
    do
    begin
      @(posedge pclk);
    end
    while (cycle_phases[3] !== 1'b1);
    #1;
    chk("imem_addr", {20'h0, ea}, {20'h0, imem_addr});
    chk("exec_valid", {31'h0, ev}, {31'h0, exec_valid});
    chk("cycle_phases", 32'h1, {28'h0, cycle_phases});
  endtask

  // One APB transfer, held until pready
  task automatic apb(logic wr, logic [11:0] ad, logic [31:0] wd);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic t_reset;
    chk("imem_addr", 32'h0, {20'h0, imem_addr});
    chk("cycle_phases", 32'h1, {28'h0, cycle_phases});
    chk("exec_valid", 32'h0, {31'h0, exec_valid});
    presetn <= 1'b1;
    apb(1'b0, pss_pkg::OFS_PCL, 32'h0);
    chk("pcl", 32'h0, rd);
    step(12'h000, 1'b0);
    step(12'h001, 1'b1);
    step(12'h002, 1'b1);
  endtask

  task automatic t_branch;
    step(12'h100, 1'b0);
    step(12'h101, 1'b1);
    chk("exec_insn", 32'h2200, {16'h0, exec_insn});
    step(12'h200, 1'b0);
    step(12'h201, 1'b1);
    step(12'h101, 1'b0);
    step(12'h102, 1'b1);
    step(12'h103, 1'b0);
    step(12'h104, 1'b1);
  endtask

  task automatic t_pcl;
    apb(1'b0, pss_pkg::OFS_PCL, 32'h0);
    chk("pcl", 32'h05, rd);
    step(12'h105, 1'b1);
    apb(1'b1, pss_pkg::OFS_PCL, 32'h40);
    step(12'h140, 1'b0);
    step(12'h141, 1'b1);
    apb(1'b1, pss_pkg::OFS_IRQ_EN, 32'h3F);
    step(12'h142, 1'b1);
    apb(1'b1, pss_pkg::OFS_CTRL, 32'h1);
    step(12'h143, 1'b1);
    apb(1'b0, 12'h010, 32'h0);
    chk("pslverr", 32'h1, {31'h0, er});
    chk("prdata", 32'h0, rd);
    step(12'h144, 1'b1);
    @(posedge pclk);
    ce <= 1'b0;
    repeat (5) @(posedge pclk);
    chk("held phase", 32'h2, {28'h0, cycle_phases});
    chk("held imem_addr", 32'h144, {20'h0, imem_addr});
    ce <= 1'b1;
  endtask

  task automatic t_irq;
    for (int i = 0; i < 6; i++)
    begin
      a = imem_addr;
      @(posedge pclk);
      irq_req <= 6'h01 << i;
      @(posedge pclk);
      irq_req <= 6'h00;
      step(pss_pkg::VECTORS[i], 1'b0);
      step(pss_pkg::VECTORS[i] + 12'h001, 1'b1);
      step(a, 1'b0);
      step(a + 12'h001, 1'b1);
    end
    chk("int_ack count", 32'd6, acks);
  endtask

  task automatic t_stack;
    apb(1'b1, pss_pkg::OFS_PCL, 32'hF0);
    step(12'h1F0, 1'b0);
    step(12'h1F1, 1'b1);
    for (int k = 0; k < 8; k++)
    begin
      step(12'h400 + 12'(16 * k), 1'b0);
      step(12'h401 + 12'(16 * k), 1'b1);
    end
    @(posedge pclk);
    irq_req <= 6'h01;
    @(posedge pclk);
    irq_req <= 6'h00;
    step(12'h472, 1'b1);
    apb(1'b0, pss_pkg::OFS_STATUS, 32'h0);
    chk("pending", 32'h1, rd & 32'h1);
    step(12'h473, 1'b1);
    step(12'h461, 1'b0);
    step(pss_pkg::VECTORS[0], 1'b0);
    repeat (3) @(posedge pclk);
    chk("int_ack count", 32'd7, acks);
  endtask

  // Main sequence
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    irq_req = 6'h00;
    acks = 0;
    #1;
    pss_imem_model_inst.mem[12'h001] = 16'h1100;
    pss_imem_model_inst.mem[12'h100] = 16'h2200;
    pss_imem_model_inst.mem[12'h200] = 16'h3000;
    pss_imem_model_inst.mem[12'h101] = 16'h5000;
    pss_imem_model_inst.mem[12'h102] = 16'h1300;
    pss_imem_model_inst.mem[12'h1F0] = 16'h2400;
    pss_imem_model_inst.mem[12'h472] = 16'h3000;
    for (int i = 0; i < 6; i++)
      pss_imem_model_inst.mem[pss_pkg::VECTORS[i]] = 16'h4000;
    for (int k = 0; k < 7; k++)
      pss_imem_model_inst.mem[12'h400 + 12'(16 * k)] =
        16'h2410 + 16'(16 * k);
    repeat (10) @(posedge pclk);
    t_reset;
    t_branch;
    t_pcl;
    t_irq;
    t_stack;
    end_sim;
  end

  // Watchdog
  initial
  begin
    #25000;
    miscompares++;
    end_sim;
  end
endmodule
